// ==== verilog/ucr_pkg.sv ====
package ucr_pkg;
    localparam logic [7:0] CMD_MODE = 8'hF3;
    localparam logic [7:0] CMD_DMA = 8'hFB;
    localparam logic [7:0] CMD_IRQ = 8'hF4;
    localparam logic [7:0] CMD_LTS_BASE = 8'h40;
    localparam logic [7:0] CMD_LTS_LAST = 8'h45;
    localparam logic [3:0] DIV_RESET = 4'hB;
    localparam logic [3:0] DIV_OFF = 4'hF;
    localparam logic [7:0] DIVB_RESET = 8'h0B;
    localparam logic [7:0] DMA_RESET = 8'h00;
    localparam int DIVB_SOF_ONLY = 7;
    localparam int DMA_EN = 2;
    localparam int DMA_DIR = 3;
    localparam int DMA_RELOAD = 4;
    localparam int DMA_SOF_IRQ = 5;
    localparam int DMA_EP4_IE = 6;
    localparam int DMA_EP5_IE = 7;
    localparam int IRQ_BUS_RESET = 6;
    localparam int IRQ_SUSPEND = 7;
    localparam int REF_MHZ = 48;
    localparam int CLK_MHZ = 100;
    // phase step per cycle, 1/1024 of a reference cycle
    localparam logic [10:0] REF_STEP = 11'(REF_MHZ * 1024 / CLK_MHZ);
    typedef enum logic [1:0] {
        UCR_IDLE = 2'b00,
        UCR_D1 = 2'b01,
        UCR_D2 = 2'b11
    } ucr_phase_t;
endpackage : ucr_pkg

// ==== verilog/ucr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module ucr_regs
    import ucr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cmd_wr,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic [7:0] bus_din,
    output logic [7:0] bus_dout,
    input wire logic usb_bus_reset,
    input wire logic sof_rx,
    input wire logic suspend_change,
    input wire logic [5:0] ep_event,
    input wire logic transfer_end_strobe,
    output logic clock_output_pin,
    output logic irq_out,
    output logic [1:0] dma_burst,
    output logic dma_enable,
    output logic dma_dir,
    output logic dma_restart
);
    logic [7:0] cmd_q;
    ucr_phase_t phase_q;
    logic [7:0] clock_div_factor_q;
    logic [7:0] dma_cfg_q;
    logic [7:0] flags_lo_q;
    logic flags_hi_q;
    logic [7:0] dout_q;
    logic eot_sync;
    logic eot_prev_q;
    logic [10:0] ref_acc_q;
    logic [3:0] div_cnt_q;
    logic clk_out_q;
    logic sof_pend_q;
    logic irq_q;
    logic eot_pulse;
    logic ref_tick;
    logic [11:0] ref_sum;
    logic [7:0] ep_clear;
    logic rd_lo, rd_hi;
    logic [7:0] lo_src;
    logic [7:0] lo_clear;
    ucr_phase_t phase_d;
    logic [7:0] clock_div_factor_d;
    logic [7:0] dma_cfg_d;
    logic [7:0] dout_d;
    logic in_mode;
    logic in_dma;
    logic in_irq;
    logic in_lts;
    logic mode_div_wr;
    logic dma_cfg_wr;
    logic ep_irq;
    logic evt_irq;
    logic sof_irq;
    logic irq_d;
    logic clk_off;
    logic div_wrap;
    logic div_half;

    // transfer end comes from a pin, two flops first
    ucr_sync2 u_eot_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in(transfer_end_strobe),
        .sync_out(eot_sync)
    );

    // pin idles low and history resets low, so no false edge after reset
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            eot_prev_q <= 1'b0;
        end else begin
            eot_prev_q <= eot_sync;
        end
    end
    assign eot_pulse = eot_sync & ~eot_prev_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cmd_q <= 8'h00;
        end else if (cmd_wr) begin
            cmd_q <= bus_din;
        end
    end

    // a stray data strobe with no command open leaves the phase idle
    always_comb begin
        phase_d = phase_q;
        if (cmd_wr) begin
            phase_d = UCR_D1;
        end else if (data_wr || data_rd) begin
            unique case (phase_q)
                UCR_IDLE: phase_d = UCR_IDLE;
                UCR_D1: phase_d = UCR_D2;
                UCR_D2: phase_d = UCR_IDLE;
                default: phase_d = UCR_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            phase_q <= UCR_IDLE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // command decode shared by registers, flags and read data
    assign in_mode = (cmd_q == CMD_MODE);
    assign in_dma = (cmd_q == CMD_DMA);
    assign in_irq = (cmd_q == CMD_IRQ);
    assign in_lts = (cmd_q >= CMD_LTS_BASE) && (cmd_q <= CMD_LTS_LAST);
    assign mode_div_wr = data_wr && in_mode && (phase_q == UCR_D2);
    assign dma_cfg_wr = data_wr && in_dma && (phase_q == UCR_D1);

    // first mode byte belongs elsewhere; only the second lands here
    always_comb begin
        clock_div_factor_d = clock_div_factor_q;
        if (mode_div_wr) begin
            clock_div_factor_d = bus_din;
        end
    end

    // usb bus reset deliberately absent here
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            clock_div_factor_q <= DIVB_RESET;
        end else begin
            clock_div_factor_q <= clock_div_factor_d;
        end
    end

    // a write in the same cycle as a transfer end keeps the written byte
    always_comb begin
        dma_cfg_d = dma_cfg_q;
        if (dma_cfg_wr) begin
            dma_cfg_d = bus_din;
        end else if (eot_pulse && !dma_cfg_q[DMA_RELOAD]) begin
            dma_cfg_d[DMA_EN] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dma_cfg_q <= DMA_RESET;
        end else begin
            dma_cfg_q <= dma_cfg_d;
        end
    end

    // reload keeps enable up and signals a fresh start instead
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dma_restart <= 1'b0;
        end else begin
            dma_restart <= eot_pulse & dma_cfg_q[DMA_RELOAD] & dma_cfg_q[DMA_EN];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dma_burst <= 2'b00;
            dma_enable <= 1'b0;
            dma_dir <= 1'b0;
        end else begin
            dma_burst <= dma_cfg_q[1:0];
            dma_enable <= dma_cfg_q[DMA_EN];
            dma_dir <= dma_cfg_q[DMA_DIR];
        end
    end

    assign rd_lo = data_rd && in_irq && phase_q == UCR_D1;
    assign rd_hi = data_rd && in_irq && phase_q == UCR_D2;

    always_comb begin
        ep_clear = 8'h00;
        if (data_rd && phase_q == UCR_D1 && in_lts) begin
            ep_clear[cmd_q[2:0]] = 1'b1;
        end
    end

    // set wins over any clear in the same cycle
    assign lo_src = {suspend_change, usb_bus_reset, ep_event};
    assign lo_clear = ep_clear | ({8{rd_lo}} & 8'hC0);
    for (genvar i = 0; i < 8; i++) begin : g_lo_flag
        ucr_flag_cell u_flag (
            .ref_clk(ref_clk),
            .reset(reset),
            .set_in(lo_src[i]),
            .clear_in(lo_clear[i]),
            .flag_out(flags_lo_q[i])
        );
    end

    // dma end flag, cleared only by a read of the second byte
    ucr_flag_cell u_hi_flag (
        .ref_clk(ref_clk),
        .reset(reset),
        .set_in(eot_pulse),
        .clear_in(rd_hi),
        .flag_out(flags_hi_q)
    );

    // read data is registered, so the processor waits a cycle per byte
    always_comb begin
        if (in_irq) begin
            dout_d = (phase_q == UCR_D2) ? {7'h00, flags_hi_q} : flags_lo_q;
        end else if (in_dma) begin
            dout_d = dma_cfg_q;
        end else begin
            dout_d = 8'h00;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dout_q <= 8'h00;
        end else begin
            dout_q <= dout_d;
        end
    end
    assign bus_dout = dout_q;

    // sof pending clears with the next interrupt register read
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sof_pend_q <= 1'b0;
        end else begin
            sof_pend_q <= sof_rx | (sof_pend_q & ~rd_lo);
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end
    assign irq_out = irq_q;

    // endpoint four and five count only while their enables are up
    assign ep_irq = (|flags_lo_q[3:0]) | (flags_lo_q[4] & dma_cfg_q[DMA_EP4_IE])
        | (flags_lo_q[5] & dma_cfg_q[DMA_EP5_IE]);
    assign evt_irq = (|flags_lo_q[7:6]) | flags_hi_q;
    assign sof_irq = sof_pend_q & dma_cfg_q[DMA_SOF_IRQ];

    // sof-only mode masks every flag, the pin then follows sof alone
    always_comb begin
        if (clock_div_factor_q[DIVB_SOF_ONLY]) begin
            irq_d = sof_pend_q;
        end else begin
            irq_d = ep_irq | evt_irq | sof_irq;
        end
    end

    // 48 MHz reference as a fractional enable; edges jitter by one cycle
    assign ref_sum = {1'b0, ref_acc_q} + {1'b0, REF_STEP};
    assign ref_tick = ref_sum[10];
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ref_acc_q <= 11'h000;
        end else begin
            ref_acc_q <= {1'b0, ref_sum[9:0]};
        end
    end

    // one full output period spans divider+1 ref ticks, high for the
    // first half; an odd count leaves the duty slightly off half
    assign clk_off = (clock_div_factor_q[3:0] == DIV_OFF);
    assign div_wrap = (div_cnt_q >= clock_div_factor_q[3:0]);
    assign div_half = (div_cnt_q == {1'b0, clock_div_factor_q[3:1]});

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            div_cnt_q <= 4'h0;
            clk_out_q <= 1'b0;
        end else if (clk_off) begin
            div_cnt_q <= 4'h0;
            clk_out_q <= 1'b0;
        end else if (ref_tick) begin
            if (div_wrap) begin
                div_cnt_q <= 4'h0;
                clk_out_q <= 1'b1;
            end else begin
                div_cnt_q <= div_cnt_q + 4'h1;
                if (div_half) begin
                    clk_out_q <= 1'b0;
                end
            end
        end
    end
    assign clock_output_pin = clk_out_q;
endmodule : ucr_regs

// two flops for a pin from outside the clock domain
module ucr_sync2 (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    logic sync_q;

    // only the second flop is read outside, the first may be metastable
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : ucr_sync2

// one event flag; a set in the same cycle as a clear wins,
// so an event never slips past a read that overlaps it
module ucr_flag_cell (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic set_in,
    input wire logic clear_in,
    output logic flag_out
);
    logic flag_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else if (set_in) begin
            flag_q <= 1'b1;
        end else if (clear_in) begin
            flag_q <= 1'b0;
        end
    end

    assign flag_out = flag_q;
endmodule : ucr_flag_cell
`default_nettype wire

// ==== test/ucr_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module ucr_chk
    import ucr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cmd_wr,
    input wire logic data_wr,
    input wire logic [7:0] bus_din,
    input wire logic [7:0] bus_dout,
    input wire logic usb_bus_reset,
    input wire logic transfer_end_strobe,
    input wire logic clock_output_pin,
    input wire logic irq_out,
    input wire logic [1:0] dma_burst,
    input wire logic dma_enable,
    input wire logic dma_dir,
    input wire logic dma_restart
);
    logic [7:0] cmd_q, divb_q, cfg_q;
    logic [1:0] n_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cmd_q <= 8'h00;
            n_q <= 2'h0;
        end else if (cmd_wr) begin
            cmd_q <= bus_din;
            n_q <= 2'h0;
        end else if (data_wr) begin
            n_q <= n_q + 2'h1;
        end
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) divb_q <= DIVB_RESET;
        else if (data_wr && cmd_q == CMD_MODE && n_q == 2'h1) divb_q <= bus_din;
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) cfg_q <= DMA_RESET;
        else if (data_wr && cmd_q == CMD_DMA && n_q == 2'h0) cfg_q <= bus_din;
    end
    sequence s_dma_wr;
        data_wr && cmd_q == CMD_DMA && n_q == 2'h0;
    endsequence
    sequence s_rst_read;
        usb_bus_reset ##1 (cmd_wr && bus_din == CMD_IRQ);
    endsequence
    a_dma_write: assert property (s_dma_wr |=> ##1 dma_burst == cfg_q[1:0] && dma_dir == cfg_q[3])
        else $error("dma outputs differ from written byte");
    a_cfg_readback: assert property (cmd_wr && bus_din == CMD_DMA |=> ##1 bus_dout[1:0] == dma_burst && bus_dout[2] == dma_enable)
        else $error("dma readback differs");
    a_end_clears: assert property ($rose(transfer_end_strobe) && !cfg_q[4] |-> ##[1:6] !dma_enable)
        else $error("dma enable kept after end");
    a_reload_pulse: assert property ($rose(transfer_end_strobe) && cfg_q[4] && dma_enable |-> ##[1:6] dma_restart)
        else $error("no restart after end");
    a_restart_single: assert property (dma_restart |=> !dma_restart)
        else $error("restart longer than one cycle");
    a_clk_off: assert property (divb_q[3:0] == DIV_OFF && $past(divb_q, 3) == divb_q |-> !clock_output_pin)
        else $error("clock output runs while off");
    a_rst_flag: assert property (s_rst_read |=> ##1 bus_dout[IRQ_BUS_RESET])
        else $error("bus reset flag missing");
    a_irq_set: assert property (usb_bus_reset && !divb_q[7] |-> ##[1:3] irq_out)
        else $error("interrupt not raised");
endmodule : ucr_chk
bind ucr_regs ucr_chk chk (.*);
`default_nettype wire

// ==== test/ucr_mcu.sv ====
`timescale 1ns/1ps
`default_nettype none
module ucr_mcu
    import ucr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [7:0] bus_dout,
    output logic cmd_wr,
    output logic data_wr,
    output logic data_rd,
    output logic [7:0] bus_din
);
    initial begin
        {cmd_wr, data_wr, data_rd, bus_din} = 11'h000;
    end
    // called at a falling edge; the gap cycle avoids two drives in one step
    task automatic put(input logic c, input logic w, input logic [7:0] d);
        {cmd_wr, data_wr, data_rd, bus_din} = {c, w, !c && !w, d};
        @(negedge ref_clk);
        {cmd_wr, data_wr, data_rd, bus_din} = {3'h0, ~d};
        @(negedge ref_clk);
    endtask : put
    task automatic rd(output logic [7:0] v);
        v = bus_dout;
        put(1'b0, 1'b0, 8'h00);
    endtask : rd
    task automatic mode(input logic sof_only, input logic [3:0] div);
        put(1'b1, 1'b0, CMD_MODE);
        put(1'b0, 1'b1, 8'h00);
        put(1'b0, 1'b1, {sof_only, 1'b1, 2'b00, div});
    endtask : mode
endmodule : ucr_mcu
`default_nettype wire

// ==== test/ucr_regs_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ucr_regs_tb_top
    import ucr_pkg::*;
;
    logic ref_clk = 1'b0, reset = 1'b1, usb_bus_reset = 1'b0, sof_rx = 1'b0;
    logic suspend_change = 1'b0, transfer_end_strobe = 1'b0, cmd_wr, data_wr, data_rd;
    logic clock_output_pin, irq_out, dma_enable, dma_dir, dma_restart;
    logic [1:0] dma_burst;
    logic [5:0] ep_event = 6'h00;
    logic [7:0] bus_din, bus_dout, v, e;
    int n_errors = 0, check_count = 0, cyc = 0;
    always #5 ref_clk = ~ref_clk;
    ucr_regs uut (.*);
    ucr_mcu mcu (.*);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic results;
        if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    // edges in the 2 us window: reference over divider+1, none when off
    function automatic int exp_edges(input logic [3:0] div);
        return (div == DIV_OFF) ? 0 : 2 * REF_MHZ / (int'(div) + 1);
    endfunction : exp_edges
    // edges over 2 us; one edge of slack for the 10 ns jitter
    task automatic rate(input int exp_n);
        int n = 0;
        logic p = 1'b0;
        repeat (200) begin
            @(posedge ref_clk);
            n += int'(clock_output_pin && !p);
            p = clock_output_pin;
        end
        @(negedge ref_clk);
        chk(8'((n - exp_n) * (n - exp_n) <= 1), 8'h01);
    endtask : rate
    task automatic irq_read(input logic [7:0] lo, input logic [7:0] hi);
        mcu.put(1'b1, 1'b0, CMD_IRQ);
        mcu.rd(v);
        chk(v, lo);
        mcu.rd(v);
        chk({7'h00, v[0]}, hi);
    endtask : irq_read
    task automatic dma_wr(input logic [7:0] d);
        mcu.put(1'b1, 1'b0, CMD_DMA);
        mcu.put(1'b0, 1'b1, d);
    endtask : dma_wr
    task automatic end_xfer(input logic [7:0] d, input logic en);
        dma_wr(d);
        transfer_end_strobe = 1'b1;
        repeat (3) @(negedge ref_clk);
        transfer_end_strobe = 1'b0;
        repeat (6) @(negedge ref_clk);
        chk({7'h00, dma_enable}, {7'h00, en});
    endtask : end_xfer
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        v = 8'($urandom(44));
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        reset = 1'b0;
        rate(exp_edges(DIV_RESET));
        {usb_bus_reset, suspend_change} = 2'b11;
        @(negedge ref_clk);
        {usb_bus_reset, suspend_change} = 2'b00;
        irq_read(8'hC0, 8'h00);
        chk({7'h00, irq_out}, 8'h00);
        rate(exp_edges(DIV_RESET));
        mcu.mode(1'b0, 4'h2);
        rate(exp_edges(4'h2));
        mcu.mode(1'b0, DIV_OFF);
        rate(exp_edges(DIV_OFF));
        repeat (4) begin
            e = 8'($urandom);
            dma_wr(e);
            chk({4'h0, dma_dir, dma_enable, dma_burst}, {4'h0, e[3:0]});
            mcu.put(1'b1, 1'b0, CMD_DMA);
            mcu.rd(v);
            chk(v, e);
        end
        end_xfer(8'h04, 1'b0);
        end_xfer(8'h14, 1'b1);
        chk({7'h00, irq_out}, 8'h01);
        irq_read(8'h00, 8'h01);
        irq_read(8'h00, 8'h00);
        dma_wr(8'h00);
        ep_event = 6'h11;
        @(negedge ref_clk);
        ep_event = 6'h00;
        irq_read(8'h11, 8'h00);
        irq_read(8'h11, 8'h00);
        mcu.put(1'b1, 1'b0, CMD_LTS_BASE);
        mcu.rd(v);
        irq_read(8'h10, 8'h00);
        chk({7'h00, irq_out}, 8'h00);
        dma_wr(8'h20);
        sof_rx = 1'b1;
        @(negedge ref_clk);
        sof_rx = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk({7'h00, irq_out}, 8'h01);
        results();
    end
endmodule : ucr_regs_tb_top
`default_nettype wire
